/* hw/short_retry_and_blanking_pkg.sv */
`default_nettype none
package short_retry_and_blanking_pkg;
  // register offsets (printed offsets are not multiples of four: kept as indices)
  localparam logic [7:0] idx_pick_ef = 8'h76;
  localparam logic [7:0] idx_pick_gh = 8'h77;
  localparam logic [7:0] idx_zero_level = 8'h78;
  localparam logic [7:0] idx_one_level = 8'h79;
  localparam logic [7:0] idx_reference = 8'h7a;
  localparam logic [7:0] idx_retry_blank = 8'h7b;
  // writable bits of the threshold pick registers
  localparam logic [7:0] pick_write_mask = 8'h77;
  // field positions
  localparam int retry_and_blanking_enable_bit = 7;
  localparam int ratio_lsb = 5;
  localparam int retry_lsb = 4;
  // bus answers
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  // reset values of bus state
  localparam logic [31:0] rdata_reset = 32'h0;
  // reference ratio codes give 64, 128, 256, 512
  localparam logic [9:0] ratio_base = 10'h040;
  // blank time table in microseconds, codes 0 to f
  localparam logic [12:0] blank_us_table [16] = '{
    13'h0064, 13'h0014, 13'h001e, 13'h0032, 13'h0050, 13'h0096, 13'h00c8, 13'h012c,
    13'h01f4, 13'h0320, 13'h03e8, 13'h04b0, 13'h05dc, 13'h07d0, 13'h0bb8, 13'h0fa0};
endpackage
`default_nettype wire

/* hw/pick_mux.sv */
`default_nettype none
// picks one of the two shared levels for each of twelve channels
module pick_mux (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // selects and levels
  input wire logic [11:0] pick,
  input wire logic [7:0] level_zero,
  input wire logic [7:0] level_one,
  // per-channel level code
  output logic [95:0] chan_level
);
  import short_retry_and_blanking_pkg::*;
  genvar i;
  generate
    for (i = 0; i < 12; i++) begin : g_ch
      wire logic [7:0] sel_level;
      assign sel_level = pick[i] ? level_one : level_zero;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) chan_level[i*8 +: 8] <= 8'h00;
        else chan_level[i*8 +: 8] <= sel_level;
      end
      a_pick_follow: assert property (@(posedge clk) disable iff (!rst_n)
        chan_level[i*8 +: 8] == ($past(pick[i]) ? $past(level_one) : $past(level_zero)))
        else $error("channel level does not follow its select");
    end
  endgenerate
endmodule // pick_mux
`default_nettype wire

/* hw/short_retry_and_blanking_regs.sv */
// Added by the designer: the AXI4-Lite slave port.
`default_nettype none
// Operation
// - select 0 uses shared threshold zero, select 1 uses shared threshold one
// - register 76h holds group E selects in bits 2-0, group F in 6-4
// - register 77h holds group G selects in bits 2-0, group H in 6-4
// - every field loads from the stored image at reset; here reset clears them to 0, the image loads on load_image
// - threshold zero code sets level code*0.125 V plus 2.5 V
// - threshold one code sets level code*0.125 V plus 2.5 V
// - reference bit 7 enables retry and blanking
// - reference bits 6-5 select ratio 64, 128, 256 or 512
// - reference bits 4-0 set supply low level code*1 V plus 4 V
// - retry register upper nibble sets retry current (code*4+4)/64 of full range
// - retry register lower nibble selects blank time, 100 us at code 0
module short_retry_and_blanking_regs (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // stored image, valid while load_image is high
  input wire logic load_image,
  input wire logic [47:0] image,
  // axi4-lite write address and data
  input wire logic [31:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  // axi4-lite write response
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // axi4-lite read
  input wire logic [31:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // outputs to the diagnostic core
  output logic [95:0] chan_level,
  output logic [7:0] level_zero_code,
  output logic [7:0] level_one_code,
  output logic retry_and_blanking_enable,
  output logic [9:0] ref_ratio,
  output logic [4:0] supply_low_level,
  output logic [3:0] retry_current_code,
  output logic [12:0] blank_time_us
);
  import short_retry_and_blanking_pkg::*;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_resp = 2'b01
  } wr_state_type;

  // register-address decode shared by read and write
  function automatic logic [2:0] reg_slot(input logic [31:0] a);
    if (a[1:0] != 2'b00) reg_slot = 3'h7;
    else if (a[31:2] == {22'h0, idx_pick_ef}) reg_slot = 3'h0;
    else if (a[31:2] == {22'h0, idx_pick_gh}) reg_slot = 3'h1;
    else if (a[31:2] == {22'h0, idx_zero_level}) reg_slot = 3'h2;
    else if (a[31:2] == {22'h0, idx_one_level}) reg_slot = 3'h3;
    else if (a[31:2] == {22'h0, idx_reference}) reg_slot = 3'h4;
    else if (a[31:2] == {22'h0, idx_retry_blank}) reg_slot = 3'h5;
    else reg_slot = 3'h7;
  endfunction

  // reset synchroniser
  logic rst_meta_ff;
  logic rst_n_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // register storage
  logic [7:0] regs_ff [6];
  logic [7:0] nxt_regs [6];

  // write channel capture
  logic aw_held_ff;
  logic w_held_ff;
  logic [31:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  wr_state_type wr_state_ff;
  wire logic aw_take = s_awvalid && s_awready;
  wire logic w_take = s_wvalid && s_wready;
  wire logic have_aw = aw_held_ff || aw_take;
  wire logic have_w = w_held_ff || w_take;
  wire logic [31:0] cur_awaddr = aw_held_ff ? awaddr_ff : s_awaddr;
  wire logic [31:0] cur_wdata = w_held_ff ? wdata_ff : s_wdata;
  wire logic [3:0] cur_wstrb = w_held_ff ? wstrb_ff : s_wstrb;
  wire logic do_write = (wr_state_ff == st_idle) && have_aw && have_w;
  wire logic [2:0] wr_slot = reg_slot(cur_awaddr);
  wire logic wr_hit = (wr_slot != 3'h7) && cur_wstrb[0];
  wire logic [7:0] wr_byte = cur_wdata[7:0];

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 32'h0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
    end else begin
      aw_held_ff <= have_aw && !do_write;
      w_held_ff <= have_w && !do_write;
      if (aw_take) awaddr_ff <= s_awaddr;
      if (w_take) wdata_ff <= s_wdata;
      if (w_take) wstrb_ff <= s_wstrb;
    end
  end

  // write response state
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      wr_state_ff <= st_idle;
      s_bvalid <= 1'b0;
      s_bresp <= resp_okay;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
    end else begin
      case (wr_state_ff)
        st_idle: begin
          if (do_write) begin
            wr_state_ff <= st_resp;
            s_bvalid <= 1'b1;
            s_bresp <= (wr_slot == 3'h7) ? resp_slverr : resp_okay;
          end
        end
        st_resp: begin
          if (s_bready) begin
            wr_state_ff <= st_idle;
            s_bvalid <= 1'b0;
          end
        end
        default: wr_state_ff <= st_idle;
      endcase
      s_awready <= !have_aw && !do_write && (wr_state_ff == st_idle)
                   && !(s_awready && s_awvalid);
      s_wready <= !have_w && !do_write && (wr_state_ff == st_idle)
                  && !(s_wready && s_wvalid);
    end
  end

  // next register values: image load wins, then bus write
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_reg
      wire logic [7:0] keep_mask = (g < 2) ? pick_write_mask : 8'hff;
      always_comb begin
        nxt_regs[g] = regs_ff[g];
        if (load_image) nxt_regs[g] = image[g*8 +: 8] & keep_mask;
        else if (do_write && wr_hit && (wr_slot == 3'(g)))
          nxt_regs[g] = wr_byte & keep_mask;
      end
      always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) regs_ff[g] <= 8'h00;
        else regs_ff[g] <= nxt_regs[g];
      end
    end
  endgenerate

  // read channel
  wire logic [2:0] rd_slot = reg_slot(s_araddr);
  wire logic [7:0] rd_byte = (rd_slot == 3'h7) ? 8'h00 : regs_ff[rd_slot];
  wire logic rd_take = s_arvalid && s_arready;
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= rdata_reset;
      s_rresp <= resp_okay;
    end else begin
      s_arready <= !s_rvalid && !rd_take && !s_arready;
      if (rd_take) begin
        s_rvalid <= 1'b1;
        s_rdata <= {24'h0, rd_byte};
        s_rresp <= (rd_slot == 3'h7) ? resp_slverr : resp_okay;
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // field decode toward the diagnostic core
  wire logic [11:0] pick_bits = {regs_ff[1][6:4], regs_ff[1][2:0],
                                 regs_ff[0][6:4], regs_ff[0][2:0]};
  wire logic [1:0] ratio_code = regs_ff[4][ratio_lsb +: 2];
  wire logic [3:0] blank_code = regs_ff[5][3:0];
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      level_zero_code <= 8'h00;
      level_one_code <= 8'h00;
      retry_and_blanking_enable <= 1'b0;
      ref_ratio <= ratio_base;
      supply_low_level <= 5'h00;
      retry_current_code <= 4'h0;
      blank_time_us <= blank_us_table[0]; // decode of the all-zero register
    end else begin
      level_zero_code <= regs_ff[2];
      level_one_code <= regs_ff[3];
      retry_and_blanking_enable <= regs_ff[4][retry_and_blanking_enable_bit];
      ref_ratio <= ratio_base << ratio_code;
      supply_low_level <= regs_ff[4][4:0];
      retry_current_code <= regs_ff[5][retry_lsb +: 4];
      blank_time_us <= blank_us_table[blank_code];
    end
  end

  pick_mux u_pick (
    .clk(clk),
    .rst_n(rst_n_ff),
    .pick(pick_bits),
    .level_zero(regs_ff[2]),
    .level_one(regs_ff[3]),
    .chan_level(chan_level)
  );

  // reserved select bits never hold a one
  a_resv_zero: assert property (@(posedge clk) disable iff (!rst_n_ff)
    (regs_ff[0][7] == 1'b0) && (regs_ff[0][3] == 1'b0) && (regs_ff[1][7] == 1'b0)
    && (regs_ff[1][3] == 1'b0)) else $error("reserved select bit set");

  // every register takes its byte of the stored image on a load
  a_image_ef: assert property (@(posedge clk) disable iff (!rst_n_ff)
    load_image |=> regs_ff[0] == ($past(image[7:0]) & pick_write_mask))
    else $error("image not loaded into pick ef");
  a_image_gh: assert property (@(posedge clk) disable iff (!rst_n_ff)
    load_image |=> regs_ff[1] == ($past(image[15:8]) & pick_write_mask))
    else $error("image not loaded into pick gh");
  a_image_load: assert property (@(posedge clk) disable iff (!rst_n_ff)
    load_image |=> regs_ff[2] == $past(image[23:16]))
    else $error("image not loaded");
  a_image_one: assert property (@(posedge clk) disable iff (!rst_n_ff)
    load_image |=> regs_ff[3] == $past(image[31:24]))
    else $error("image not loaded into level one");
  a_image_ref: assert property (@(posedge clk) disable iff (!rst_n_ff)
    load_image |=> regs_ff[4] == $past(image[39:32]))
    else $error("image not loaded into reference");
  a_image_retry: assert property (@(posedge clk) disable iff (!rst_n_ff)
    load_image |=> regs_ff[5] == $past(image[47:40]))
    else $error("image not loaded into retry");

  // decoded outputs follow their fields one cycle later
  a_enable_follow: assert property (@(posedge clk) disable iff (!rst_n_ff)
    ##1 retry_and_blanking_enable == $past(regs_ff[4][7])) else $error("enable lost");
  a_ratio_map: assert property (@(posedge clk) disable iff (!rst_n_ff)
    ##1 ref_ratio == (ratio_base << $past(regs_ff[4][6:5]))) else $error("bad ratio");
  a_ratio_code0: assert property (@(posedge clk) disable iff (!rst_n_ff)
    regs_ff[4][6:5] == 2'h0 |=> ref_ratio == 10'h040)
    else $error("ratio code 0 not 64");
  a_ratio_code1: assert property (@(posedge clk) disable iff (!rst_n_ff)
    regs_ff[4][6:5] == 2'h1 |=> ref_ratio == 10'h080)
    else $error("ratio code 1 not 128");
  a_ratio_code2: assert property (@(posedge clk) disable iff (!rst_n_ff)
    regs_ff[4][6:5] == 2'h2 |=> ref_ratio == 10'h100)
    else $error("ratio code 2 not 256");
  a_ratio_code3: assert property (@(posedge clk) disable iff (!rst_n_ff)
    regs_ff[4][6:5] == 2'h3 |=> ref_ratio == 10'h200)
    else $error("ratio code 3 not 512");
  a_supply_level: assert property (@(posedge clk) disable iff (!rst_n_ff)
    ##1 supply_low_level == $past(regs_ff[4][4:0])) else $error("supply level");
  a_retry_code: assert property (@(posedge clk) disable iff (!rst_n_ff)
    ##1 retry_current_code == $past(regs_ff[5][7:4])) else $error("retry code");
  a_level_zero: assert property (@(posedge clk) disable iff (!rst_n_ff)
    ##1 level_zero_code == $past(regs_ff[2])) else $error("level zero");
  a_level_one: assert property (@(posedge clk) disable iff (!rst_n_ff)
    ##1 level_one_code == $past(regs_ff[3])) else $error("level one");

  // blank time at both ends of the table and at code one
  a_blank_zero: assert property (@(posedge clk) disable iff (!rst_n_ff)
    regs_ff[5][3:0] == 4'h0 ##1 regs_ff[5][3:0] == 4'h0 |-> blank_time_us == 13'h0064)
    else $error("blank code 0 not 100 us");
  a_blank_one: assert property (@(posedge clk) disable iff (!rst_n_ff)
    regs_ff[5][3:0] == 4'h1 ##1 regs_ff[5][3:0] == 4'h1 |-> blank_time_us == 13'h0014)
    else $error("blank code 1 not 20 us");
  a_blank_top: assert property (@(posedge clk) disable iff (!rst_n_ff)
    regs_ff[5][3:0] == 4'hf ##1 regs_ff[5][3:0] == 4'hf |-> blank_time_us == 13'h0fa0)
    else $error("blank code f not 4 ms");

  // an accepted bus byte lands in its register, reserved bits masked
  a_pick_ef_write: assert property (@(posedge clk) disable iff (!rst_n_ff)
    do_write && wr_hit && wr_slot == 3'h0 && !load_image
    |=> regs_ff[0] == ($past(wr_byte) & pick_write_mask))
    else $error("pick ef write");
  a_pick_gh_write: assert property (@(posedge clk) disable iff (!rst_n_ff)
    do_write && wr_hit && wr_slot == 3'h1 && !load_image
    |=> regs_ff[1] == ($past(wr_byte) & pick_write_mask))
    else $error("pick gh write");
  a_zero_write: assert property (@(posedge clk) disable iff (!rst_n_ff)
    do_write && wr_hit && wr_slot == 3'h2 && !load_image
    |=> regs_ff[2] == $past(wr_byte))
    else $error("level zero write");
  a_one_write: assert property (@(posedge clk) disable iff (!rst_n_ff)
    do_write && wr_hit && wr_slot == 3'h3 && !load_image
    |=> regs_ff[3] == $past(wr_byte))
    else $error("level one write");
  a_ref_write: assert property (@(posedge clk) disable iff (!rst_n_ff)
    do_write && wr_hit && wr_slot == 3'h4 && !load_image
    |=> regs_ff[4] == $past(wr_byte))
    else $error("reference write");
  a_retry_write: assert property (@(posedge clk) disable iff (!rst_n_ff)
    do_write && wr_hit && wr_slot == 3'h5 && !load_image
    |=> regs_ff[5] == $past(wr_byte))
    else $error("retry write");

  // with no load and no accepted byte a register keeps its value
  a_hold_ef: assert property (@(posedge clk) disable iff (!rst_n_ff)
    !load_image && !(do_write && wr_hit && wr_slot == 3'h0) |=> $stable(regs_ff[0]))
    else $error("pick ef changed on its own");
  a_hold_gh: assert property (@(posedge clk) disable iff (!rst_n_ff)
    !load_image && !(do_write && wr_hit && wr_slot == 3'h1) |=> $stable(regs_ff[1]))
    else $error("pick gh changed on its own");
  a_hold_zero: assert property (@(posedge clk) disable iff (!rst_n_ff)
    !load_image && !(do_write && wr_hit && wr_slot == 3'h2) |=> $stable(regs_ff[2]))
    else $error("level zero changed on its own");
  a_hold_one: assert property (@(posedge clk) disable iff (!rst_n_ff)
    !load_image && !(do_write && wr_hit && wr_slot == 3'h3) |=> $stable(regs_ff[3]))
    else $error("level one changed on its own");
  a_hold_ref: assert property (@(posedge clk) disable iff (!rst_n_ff)
    !load_image && !(do_write && wr_hit && wr_slot == 3'h4) |=> $stable(regs_ff[4]))
    else $error("reference changed on its own");
  a_hold_retry: assert property (@(posedge clk) disable iff (!rst_n_ff)
    !load_image && !(do_write && wr_hit && wr_slot == 3'h5) |=> $stable(regs_ff[5]))
    else $error("retry changed on its own");

  // lane mapping from select bits to channel levels
  a_lane_e0: assert property (@(posedge clk) disable iff (!rst_n_ff)
    chan_level[7:0] == ($past(regs_ff[0][0]) ? $past(regs_ff[3]) : $past(regs_ff[2])))
    else $error("group e channel 0 level");
  a_lane_f0: assert property (@(posedge clk) disable iff (!rst_n_ff)
    chan_level[31:24] == ($past(regs_ff[0][4]) ? $past(regs_ff[3]) : $past(regs_ff[2])))
    else $error("group f channel 0 level");
  a_lane_g0: assert property (@(posedge clk) disable iff (!rst_n_ff)
    chan_level[55:48] == ($past(regs_ff[1][0]) ? $past(regs_ff[3]) : $past(regs_ff[2])))
    else $error("group g channel 0 level");
  a_lane_h2: assert property (@(posedge clk) disable iff (!rst_n_ff)
    chan_level[95:88] == ($past(regs_ff[1][6]) ? $past(regs_ff[3]) : $past(regs_ff[2])))
    else $error("group h channel 2 level");
endmodule // short_retry_and_blanking_regs
`default_nettype wire

/* bench/short_retry_and_blanking_regs_tb.sv */
`default_nettype none
module short_retry_and_blanking_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import short_retry_and_blanking_pkg::*;
  logic clk, resetn, load_image;
  logic [47:0] image;
  logic [31:0] s_awaddr, s_wdata, s_araddr, s_rdata;
  logic [3:0] s_wstrb;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  logic [1:0] s_bresp, s_rresp;
  logic [95:0] chan_level;
  logic [7:0] level_zero_code, level_one_code;
  logic retry_and_blanking_enable;
  logic [9:0] ref_ratio;
  logic [4:0] supply_low_level;
  logic [3:0] retry_current_code;
  logic [12:0] blank_time_us;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [7:0] shadow [6];
  logic [1:0] resp;
  logic [31:0] rd;
  // reference ratio for codes 0 to 3
  localparam logic [9:0] ratio_exp [4] = '{10'h040, 10'h080, 10'h100, 10'h200};
  // device under test
  short_retry_and_blanking_regs dut (
    .clk, .resetn, .load_image, .image,
    .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
    .s_bresp, .s_bvalid, .s_bready,
    .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
    .chan_level, .level_zero_code, .level_one_code, .retry_and_blanking_enable, .ref_ratio,
    .supply_low_level, .retry_current_code, .blank_time_us
  );
  // 100 mhz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // cuts a hang short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      num_errors++;
      close_out();
    end
  end
  // compares one value and counts it
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one bus write; address and data offered together, each released when taken
  task automatic axi_write(input logic [7:0] idx, input logic [7:0] data,
                           input logic [3:0] strb, output logic [1:0] r);
    @(posedge clk);
    s_awaddr <= {22'h0, idx, 2'h0};
    s_wdata <= {24'h0, data};
    s_wstrb <= strb;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1);
    r = s_bresp;
    s_bready <= 1'b0;
  endtask
  // one bus read
  task automatic axi_read(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_araddr <= {22'h0, idx, 2'h0};
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1);
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
  endtask
  // write a register, track the expected content, let the outputs settle
  task automatic wr(input logic [7:0] idx, input logic [7:0] data);
    axi_write(idx, data, 4'hf, resp);
    check(32'(resp), 32'(resp_okay));
    shadow[idx - 8'h76] = (idx < 8'h78) ? (data & 8'h77) : data;
    repeat (3) @(posedge clk);
  endtask
  // read every register back and compare every decoded output
  task automatic check_all;
    logic [11:0] pk;
    for (int i = 0; i < 6; i++) begin
      axi_read(8'h76 + 8'(i), rd, resp);
      check(32'(resp), 32'(resp_okay));
      check(rd, {24'h0, shadow[i]});
    end
    pk = {shadow[1][6:4], shadow[1][2:0], shadow[0][6:4], shadow[0][2:0]};
    for (int c = 0; c < 12; c++)
      check(32'(chan_level[8*c+:8]), 32'(pk[c] ? shadow[3] : shadow[2]));
    check(32'(level_zero_code), 32'(shadow[2]));
    check(32'(level_one_code), 32'(shadow[3]));
    check(32'(retry_and_blanking_enable), 32'(shadow[4][7]));
    check(32'(ref_ratio), 32'(ratio_exp[shadow[4][6:5]]));
    check(32'(supply_low_level), 32'(shadow[4][4:0]));
    check(32'(retry_current_code), 32'(shadow[5][7:4]));
    check(32'(blank_time_us), 32'(blank_us_table[shadow[5][3:0]]));
  endtask
  // load the stored image, reserved bits set in it must not show
  task automatic t_image(input logic [47:0] img);
    @(posedge clk);
    image <= img;
    load_image <= 1'b1;
    @(posedge clk);
    load_image <= 1'b0;
    for (int i = 0; i < 6; i++) shadow[i] = (i < 2) ? (img[8*i+:8] & 8'h77) : img[8*i+:8];
    repeat (3) @(posedge clk);
    check_all();
    $display("image load test done");
  endtask
  // write registers 76h to 7ah, reserved bits included, and every reference ratio code
  task automatic t_writes;
    wr(8'h76, 8'hac);
    wr(8'h77, 8'h9d);
    wr(8'h78, 8'h00);
    wr(8'h79, 8'hff);
    for (int c = 0; c < 4; c++) begin
      wr(8'h7a, {c[0], c[1:0], 5'(c * 9)});
      check_all();
    end
    $display("register write test done");
  endtask
  // blank time codes at both ends and code one, with retry codes
  task automatic t_blank;
    wr(8'h7b, 8'h00);
    check(32'(blank_time_us), 32'h0064);
    wr(8'h7b, 8'h51);
    check(32'(blank_time_us), 32'h0014);
    wr(8'h7b, 8'hff);
    check(32'(blank_time_us), 32'h0fa0);
    check_all();
    $display("blank time test done");
  endtask
  // unmapped place and a write with no byte enabled leave everything alone
  task automatic t_bad;
    axi_write(8'h7c, 8'h5a, 4'hf, resp);
    check(32'(resp), 32'(resp_slverr));
    axi_read(8'h7c, rd, resp);
    check(32'(resp), 32'(resp_slverr));
    check(rd, 32'h0);
    axi_write(8'h78, 8'h33, 4'h0, resp);
    check(32'(resp), 32'(resp_okay));
    repeat (3) @(posedge clk);
    check_all();
    $display("refused access test done");
  endtask
  // main sequence
  initial begin
    resetn = 1'b0;
    load_image = 1'b0;
    image = 48'h0;
    s_awaddr = 32'h0;
    s_wdata = 32'h0;
    s_wstrb = 4'h0;
    s_araddr = 32'h0;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    t_image(48'h3f_9b_ed_12_5a_ff);
    t_writes();
    t_blank();
    t_bad();
    t_image(48'h8e_e4_21_c3_88_03);
    close_out();
  end
endmodule // short_retry_and_blanking_regs_tb
`default_nettype wire
